// file: cacs_top.sv
// Control and status register with shared counter of the counter array
`timescale 1ns/1ps
module cacs_top
   import cacs_pkg::*;
(
   // Clock and reset
   input  wire logic                        clk_in,
   input  wire logic                        nrst_in,
   // Register bus
   input  wire cacs_bus_t                   bus_in,
   output logic      [7:0]                  rdata_out,
   // Module events and enables
   input  wire logic [CACS_NUM_MODULES-1:0] module_event_in,
   input  wire logic [CACS_NUM_MODULES-1:0] module_int_en_in,
   input  wire logic                        ovf_int_en_in,
   input  wire logic                        watchdog_en_in,
   // Status
   output logic                             irq_out,
   output logic      [15:0]                 count_out,
   output logic                             count_tick_out,
   output logic                             watchdog_force_out,
   output logic                             system_clock_div_tick_out
);
   // Control bits
   logic                        ovf_reg, ovf_next;
   logic                        run_reg, run_next;
   // Module flags and forced watchdog reset
   logic [CACS_NUM_MODULES-1:0] mflag_reg, mflag_next;
   logic                        wdf_reg, wdf_next;
   // Shared counter and its prescaler
   logic [15:0]                 cnt_reg, cnt_next;
   logic [3:0]                  pre_reg, pre_next;
   logic                        tick_reg, tick_next;
   // Divide by eight enable
   logic [2:0]                  cdiv_reg, cdiv_next;
   logic                        cdt_reg, cdt_next;
   // Read data and interrupt request
   logic [7:0]                  rdata_reg, rdata_next;
   logic                        irq_reg, irq_next;
   // Decoded bus access, plus counter run and wrap terms
   logic                        sel;
   logic                        wr_ovf;
   logic                        wr_run;
   logic                        kick;
   logic                        eff_run;
   logic                        wrap;
   logic [7:0]                  wval;
   logic [7:0]                  wmask;
   logic [7:0]                  cur;

   // Apply byte write or single bit write to current value
   function automatic logic [7:0] merge(input logic [7:0] old,
                                         input cacs_bus_t b);
      logic [7:0] r;
      r = old;
      if (b.wr) begin
         r = b.wdata;
      end else if (b.bit_wr) begin
         r[b.bit_sel] = b.wdata[0];
      end
      return r;
   endfunction : merge

   // Bus decode, shared by the control bit, module flag and read data groups below
   always_comb begin
      sel   = (bus_in.addr == CACS_ADDR);
      cur   = {ovf_reg, run_reg, 1'b0, mflag_reg};
      wval  = merge(cur, bus_in);
      wmask = 8'h00;
      if (sel && bus_in.wr) begin
         wmask = 8'hff;
      end else if (sel && bus_in.bit_wr) begin
         wmask[bus_in.bit_sel] = 1'b1;
      end
      wr_ovf = wmask[CACS_OVF_BIT];
      wr_run = wmask[CACS_RUN_BIT];
      // With the watchdog enabled, a one into module four flag is a reset request, not a flag set
      kick   = watchdog_en_in && wmask[CACS_MOD4_BIT]
               && wval[CACS_MOD4_BIT];
   end

   // Shared counter
   always_comb begin
      // Watchdog forces counting without touching the run bit
      eff_run   = run_reg | watchdog_en_in;
      tick_next = 1'b0;
      pre_next  = pre_reg;
      if (eff_run) begin
         if (pre_reg == CACS_PRESCALE - 4'h1) begin
            pre_next  = 4'h0;
            tick_next = 1'b1;
         end else begin
            pre_next = pre_reg + 4'h1;
         end
      end
      wrap     = tick_next && (cnt_reg == CACS_COUNT_MAX);
      cnt_next = cnt_reg;
      if (tick_next) begin
         cnt_next = cnt_reg + 16'h0001;
      end
   end

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         cnt_reg  <= 16'h0000;
         pre_reg  <= 4'h0;
         tick_reg <= 1'b0;
      end else begin
         cnt_reg  <= cnt_next;
         pre_reg  <= pre_next;
         tick_reg <= tick_next;
      end
   end

   // Divide by eight enable standing in for the reset system clock
   always_comb begin
      cdt_next  = (cdiv_reg == CACS_CLKDIV_RST);
      cdiv_next = cdiv_reg + 3'h1;
   end

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         cdiv_reg <= 3'h0;
         cdt_reg  <= 1'b0;
      end else begin
         cdiv_reg <= cdiv_next;
         cdt_reg  <= cdt_next;
      end
   end

   // Control bits
   always_comb begin
      run_next = run_reg;
      // Run bit keeps the software value while the watchdog owns the counter
      if (wr_run && !watchdog_en_in) begin
         run_next = wval[CACS_RUN_BIT];
      end
      ovf_next = ovf_reg;
      if (wr_ovf) begin
         ovf_next = wval[CACS_OVF_BIT];
      end
      // Set wins over a same-cycle clear so no wrap is lost
      if (wrap) begin
         ovf_next = 1'b1;
      end
   end

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         ovf_reg <= CACS_RESET[CACS_OVF_BIT];
         run_reg <= CACS_RESET[CACS_RUN_BIT];
      end else begin
         ovf_reg <= ovf_next;
         run_reg <= run_next;
      end
   end

   // Module flags and forced watchdog reset
   always_comb begin
      mflag_next = (wval[CACS_NUM_MODULES-1:0]
                    & wmask[CACS_NUM_MODULES-1:0])
                 | (mflag_reg & ~wmask[CACS_NUM_MODULES-1:0]);
      if (kick) begin
         // Reset request leaves the stored flag as it was
         mflag_next[CACS_MOD4_BIT] = mflag_reg[CACS_MOD4_BIT];
      end
      // Events applied last so a set beats a same-cycle clear
      mflag_next = mflag_next | module_event_in;
      wdf_next   = kick;
   end

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         mflag_reg <= CACS_RESET[CACS_NUM_MODULES-1:0];
         wdf_reg   <= 1'b0;
      end else begin
         mflag_reg <= mflag_next;
         wdf_reg   <= wdf_next;
      end
   end

   // Read data and shared interrupt request
   always_comb begin
      irq_next   = (ovf_reg & ovf_int_en_in)
                 | (|(mflag_reg & module_int_en_in));
      // Run bit reads the stored software value; bit five reads zero
      rdata_next = 8'h00;
      if (sel && bus_in.rd) begin
         rdata_next = cur;
      end
   end

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         rdata_reg <= 8'h00;
         irq_reg   <= 1'b0;
      end else begin
         rdata_reg <= rdata_next;
         irq_reg   <= irq_next;
      end
   end

   assign rdata_out           = rdata_reg;
   assign irq_out             = irq_reg;
   assign count_out           = cnt_reg;
   assign count_tick_out      = tick_reg;
   assign watchdog_force_out  = wdf_reg;
   assign system_clock_div_tick_out = cdt_reg;
endmodule : cacs_top

// file: cacs_pkg.sv
// Constants and carriers for the counter array control and status register
package cacs_pkg;
   localparam logic [7:0]  CACS_ADDR        = 8'hd8;
   localparam logic [7:0]  CACS_RESET       = 8'h00;
   localparam int          CACS_OVF_BIT     = 7;
   localparam int          CACS_RUN_BIT     = 6;
   localparam int          CACS_UNUSED_BIT  = 5;
   localparam int          CACS_MOD4_BIT    = 4;
   localparam int          CACS_NUM_MODULES = 5;
   localparam logic [3:0]  CACS_PRESCALE    = 4'hc;
   localparam logic [15:0] CACS_COUNT_MAX   = 16'hffff;
   localparam logic [2:0]  CACS_CLKDIV_RST  = 3'h7;

   // Special function register bus from the processor core
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic       bit_wr;
      logic [7:0] addr;
      logic [2:0] bit_sel;
      logic [7:0] wdata;
   } cacs_bus_t;
endpackage : cacs_pkg

// file: cacs_monitor.sv
// Assertion checker for the control and status register
`timescale 1ns/1ps
module cacs_chk
   import cacs_pkg::*;
(
   input wire logic       clk_in, nrst_in, ovf_int_en_in, watchdog_en_in,
   input wire cacs_bus_t  bus_in,
   input wire logic [4:0] module_event_in, module_int_en_in,
   input wire logic [7:0] rdata_out,
   input wire logic       irq_out, count_tick_out, watchdog_force_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!nrst_in);
   logic [3:0] gap_reg;
   wire hit = bus_in.addr == CACS_ADDR;
   // Byte write wins over bit write
   wire kick = hit && (bus_in.wr ? bus_in.wdata[4] : bus_in.bit_wr
               && bus_in.bit_sel == 3'h4 && bus_in.wdata[0]);
   always_ff @(posedge clk_in or negedge nrst_in)
      if (!nrst_in) gap_reg <= 4'h0;
      else gap_reg <= (count_tick_out || !watchdog_en_in) ? 4'h0
                      : gap_reg + 4'h1;
   AST_RD_OTHER:
      assert property (bus_in.rd && !hit |=> rdata_out == 8'h00)
      else $error("off address read not zero");
   AST_BIT5:
      assert property (rdata_out[5] == 1'b0) else $error("bit five set");
   AST_KICK:
      assert property (watchdog_en_in && kick |=> watchdog_force_out)
      else $error("no watchdog force");
   AST_NOKICK:
      assert property (!(watchdog_en_in && kick) |=> !watchdog_force_out)
      else $error("stray watchdog force");
   AST_TICK:
      assert property (count_tick_out |=> !count_tick_out [*8])
      else $error("tick too soon");
   AST_WDRUN:
      assert property (gap_reg < 4'he) else $error("counter stalled");
   AST_IRQ:
      assert property ((module_event_in & module_int_en_in) != 5'h00
         ##1 $stable(module_int_en_in) |=> irq_out) else $error("no irq");
   AST_NOIRQ:
      assert property (module_int_en_in == 5'h00 && !ovf_int_en_in
         |=> !irq_out) else $error("irq while masked");
endmodule : cacs_chk
bind cacs_top cacs_chk cacs_chk_i (.*);

// file: cacs_evt_model.sv
// Capture/compare event source feeding the flag inputs
`timescale 1ns/1ps
module cacs_evt_model (
   input  wire logic       clk_in,
   input  wire logic [4:0] req_in,
   output logic      [4:0] evt_out
);
   initial evt_out = 5'h00;
   always @(posedge clk_in) evt_out <= #1 req_in;
endmodule : cacs_evt_model

// file: tb_top.sv
// Self-checking bench for the control and status register
`timescale 1ns/1ps
module tb_top;
   import cacs_pkg::*;
   logic clk_in = 0, nrst_in = 0, ovf_en = 0, wd_en = 0, irq, tick, wdf;
   logic dtk;
   logic [4:0] req = 0, evt, int_en = 0;
   logic [7:0] rdata;
   logic [15:0] cnt, c1;
   cacs_bus_t bus = '0;
   int n_errors = 0, comparisons = 0, cyc = 0, k = 0;
   cacs_evt_model cacs_evt_model_i (.clk_in(clk_in), .req_in(req),
      .evt_out(evt));
   cacs_top cacs_top_i (.clk_in(clk_in), .nrst_in(nrst_in), .bus_in(bus),
      .rdata_out(rdata), .module_event_in(evt), .module_int_en_in(int_en),
      .ovf_int_en_in(ovf_en), .watchdog_en_in(wd_en), .irq_out(irq),
      .count_out(cnt), .count_tick_out(tick), .watchdog_force_out(wdf),
      .system_clock_div_tick_out(dtk));
   task automatic close_out;
      $display("errors=%0d comparisons=%0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : close_out
   task automatic chk(input logic [15:0] got, exp);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic acc(input logic w, b, r, input logic [7:0] d,
                      input logic [2:0] s, input logic [7:0] a = CACS_ADDR);
      @(posedge clk_in); #1 bus = '{w, r, b, a, s, d};
      @(posedge clk_in); #1 bus = '0;
   endtask : acc
   task automatic rd(input logic [7:0] exp, input logic [7:0] a = CACS_ADDR);
      acc(0, 0, 1, 8'h00, 3'h0, a);
      chk(rdata, exp);
   endtask : rd
   task automatic pulse(input logic [4:0] m);
      @(posedge clk_in); #1 req = m;
      @(posedge clk_in); #1 req = 5'h00;
   endtask : pulse
   initial forever #5 clk_in = ~clk_in;
   always @(posedge clk_in) if (++cyc > 3000) begin
      n_errors++;
      close_out();
   end
   initial begin
      repeat (3) @(posedge clk_in);
      #1 nrst_in = 1;
      rd(8'h00);
      repeat (8) begin
         @(posedge clk_in);
         #1 k += dtk;
      end
      chk(16'(k), 16'h0001);
      acc(1, 0, 0, 8'hff, 3'h0); rd(8'hdf);
      rd(8'h00, 8'hd9);
      acc(1, 0, 0, 8'h00, 3'h0); rd(8'h00);
      int_en = 5'h1f;
      for (int i = 0; i < 5; i++) begin
         pulse(5'h01 << i); rd(8'h01 << i);
         chk(irq, 1'b1);
         acc(0, 1, 0, 8'h00, 3'(i)); rd(8'h00);
      end
      ovf_en = 1;
      acc(1, 0, 0, 8'h80, 3'h0);
      @(posedge clk_in);
      #1 chk(irq, 1'b1);
      acc(0, 1, 0, 8'h00, 3'h7); rd(8'h00);
      ovf_en = 0;
      int_en = 5'h00;
      pulse(5'h01); rd(8'h01); chk(irq, 1'b0);
      acc(1, 0, 0, 8'h00, 3'h0); c1 = cnt; repeat (30) @(posedge clk_in);
      chk(cnt, c1);
      acc(1, 0, 0, 8'h40, 3'h0); repeat (30) @(posedge clk_in);
      chk(cnt > c1, 1'b1);
      c1 = cnt;
      repeat (36) @(posedge clk_in);
      chk(cnt, c1 + 16'h0003);
      fork
         pulse(5'h04);
         begin
            @(posedge clk_in);
            acc(0, 1, 0, 8'h00, 3'h2);
         end
      join
      rd(8'h44);
      acc(1, 0, 0, 8'h00, 3'h0); wd_en = 1;
      acc(1, 0, 0, 8'h40, 3'h0); rd(8'h00); c1 = cnt;
      repeat (30) @(posedge clk_in);
      chk(cnt != c1, 1'b1);
      acc(0, 1, 0, 8'h01, 3'h4); chk(wdf, 1'b1);
      rd(8'h00);
      close_out();
   end
endmodule : tb_top
